// >>> acpi_rail_pkg.sv
// Purpose: Shared constants and types for the ACPI rail sequencer
// Assumes: 200 MHz aclk, AXI4-Lite register access
// Notes:   Long counts are defaults for top-level parameters
package acpi_rail_pkg;
	// Clock and documented times
	localparam int CLK_NS          = 5;
	localparam int FILT_NS         = 2000;
	localparam int S3_DELAY_US     = 200;
	localparam int STARTUP_WAIT_MS = 3;
	localparam int MAIN_WAIT_MS    = 25;
	localparam int FILT_CYC        = (FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam int S3_DELAY_CYC    = (S3_DELAY_US * 1000) / CLK_NS;
	localparam int STARTUP_CYC     = (STARTUP_WAIT_MS * 1000000) / CLK_NS;
	localparam int MAIN_WAIT_CYC   = (MAIN_WAIT_MS * 1000000) / CLK_NS;

	// Counter types
	localparam int TMR_W = 23;
	typedef logic [TMR_W-1:0] tmr_t;
	typedef logic [8:0]       flt_t;
	localparam flt_t FILT_LAST = flt_t'(FILT_CYC - 1);

	// Register map, byte addresses
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_SENSE  = 8'h08;
	localparam logic [1:0] SEL_NONE   = 2'h0;
	localparam logic [1:0] SEL_CTRL   = 2'h1;
	localparam logic [1:0] SEL_STATUS = 2'h2;
	localparam logic [1:0] SEL_SENSE  = 2'h3;
	localparam int         CTRL_SHUT  = 0;
	localparam logic       CTRL_RESET = 1'h0;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Rail indices: 0 dual 3.3V, 1 standby 1.8V, 2 memory, 3 clock, 4 dual 5V
	localparam int         NRAIL     = 5;
	localparam logic [4:0] RAIL_PH1  = 5'h03;
	localparam logic [4:0] RAIL_INT  = 5'h0a;
	localparam logic [4:0] RAIL_MEM  = 5'h04;

	typedef enum logic [2:0] {SQ_OFF, SQ_RAMP1, SQ_WAIT, SQ_RAMP2, SQ_RUN, SQ_LATCH} seq_e;
	typedef enum logic [1:0] {PW_ACTIVE, PW_S3, PW_S5} pwr_e;

	// Rail enables driven to the pass elements
	typedef struct packed {
		logic dual5;
		logic mem;
		logic sb18;
		logic dual33;
	} rails_s;

	// Asynchronous sense inputs, synchronised as one bundle
	typedef struct packed {
		logic       por_ok;
		logic       sleep3_n;
		logic       sleep5_n;
		logic       keep;
		logic       shut;
		logic       memsel;
		logic       ramp1;
		logic       ramp2;
		logic       hot140;
		logic       hot155;
		logic [2:0] atx_good;
		logic [4:0] uv;
	} sense_s;
endpackage

// >>> acpi_rail_sequencer.sv
// Purpose: Sequences five ACPI rails through active, S3 and S4/S5
// Assumes: All sense inputs asynchronous; aresetn synchronous low
// Notes:   Long timer counts are parameters so short runs stay practical
// Functional notes
// - Keep-enable tracks input only outside sleep
// - Deglitch both sleep requests, about 2us
// - S3 low starts 200us, then choose sleep
// - POR release starts first ramp phase
// - Ramp1 done: arm, wait 3ms, latch, ramp2
// - Ramp2 done: arm rest, hold until transition
// - Clock supply only when active, mains good
// - Active wake waits 25ms after mains good
// - Dual 3.3V and 1.8V up after POR
// - 25ms expiry ramps memory, raises gate drive
// - Undervoltage on an armed, enabled rail drives fault pin high
// - External-pass undervoltage only flags fault
// - Internal-pass undervoltage latches that regulator off
// - Shutdown: all off, fault low, clear latches; the code ignores it in whole-chip latch-off, where fault stays high until POR
// - Early phase-one undervoltage latches whole chip off
// - Overtemp 140 flags, 155 disables, resumes
// - Mains loss when active forces S4/S5
// - Forced S4/S5 left on recovery, POR, shutdown
// - Latch memory voltage select after ramp
// - No direct S3 to S4/S5 transitions
// - Keep-enable powers dual 5V in sleep
// - Clock supply off in every sleep state
module acpi_rail_sequencer import acpi_rail_pkg::*; #(
	parameter tmr_t S3_DELAY  = tmr_t'(S3_DELAY_CYC),
	parameter tmr_t STARTUP   = tmr_t'(STARTUP_CYC),
	parameter tmr_t MAIN_WAIT = tmr_t'(MAIN_WAIT_CYC)
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	input  wire logic        standby_por_ok,
	input  wire logic        suspend_ram_request_n,
	input  wire logic        soft_off_request_n,
	input  wire logic        sleep_keep_dual5_enable,
	input  wire logic        shutdown_pin,
	input  wire logic        memsel_compare,
	input  wire logic        ramp1_done,
	input  wire logic        ramp2_done,
	input  wire logic        temp_140,
	input  wire logic        temp_155,
	input  wire logic [2:0]  atx_good,
	input  wire logic [4:0]  rail_uv,
	output rails_s           rails,
	output logic             clock_chip_supply_out,
	output logic             active_gate_drive,
	output logic             ss_ramp1,
	output logic             ss_ramp2,
	output logic             fault_memsel_pin,
	output logic             memory_voltage_select,
	output pwr_e             power_state
);
	sense_s     sync1;
	sense_s     s;
	seq_e       seq;
	seq_e       next_seq;
	pwr_e       pw;
	pwr_e       next_pw;
	flt_t       flt_cnt [2];
	logic [1:0] filt;
	tmr_t       tmr;
	tmr_t       s3_tmr;
	tmr_t       main_tmr;
	logic       main_up;
	logic       forced;
	logic       arm1;
	logic       arm2;
	logic       keep_lat;
	logic       ot_off;
	logic [4:0] lat_off;
	logic       sw_shut;
	logic       aw_got;
	logic       w_got;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic       wstrb0_q;

	// Address decode shared by read and write paths
	function automatic logic [1:0] reg_sel(input logic [7:0] a);
		if (a == REG_CTRL)
			return SEL_CTRL;
		if (a == REG_STATUS)
			return SEL_STATUS;
		if (a == REG_SENSE)
			return SEL_SENSE;
		return SEL_NONE;
	endfunction

	// Two-stage synchroniser; nothing reads sync1 but s
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1 <= '0;
			s     <= '0;
		end else begin
			sync1 <= {standby_por_ok, suspend_ram_request_n, soft_off_request_n,
				sleep_keep_dual5_enable, shutdown_pin, memsel_compare, ramp1_done,
				ramp2_done, temp_140, temp_155, atx_good, rail_uv};
			s     <= sync1;
		end
	end

	// Deglitch: a level must differ for the whole window to pass
	wire [1:0] flt_raw = {s.sleep5_n, s.sleep3_n};
	always_ff @(posedge aclk) begin
		for (int i = 0; i < 2; i++) begin
			if (!aresetn) begin
				flt_cnt[i] <= '0;
				filt[i]    <= 1'b1;
			end else if (flt_raw[i] == filt[i]) begin
				flt_cnt[i] <= '0;
			end else if (flt_cnt[i] == FILT_LAST) begin
				filt[i]    <= flt_raw[i];
				flt_cnt[i] <= '0;
			end else begin
				flt_cnt[i] <= flt_cnt[i] + 1'b1;
			end
		end
	end

	// Shared conditions
	wire shut       = s.shut | sw_shut;
	wire wake_req   = filt[0] & filt[1];
	wire atx_ok     = &s.atx_good;
	wire running    = seq == SQ_RUN;
	wire atx_lost   = running && pw == PW_ACTIVE && main_up && !atx_ok;
	wire s3_expired = pw == PW_ACTIVE && !filt[0] && s3_tmr == '0;
	wire main_cond  = running && pw == PW_ACTIVE && atx_ok;
	wire main_start = main_cond && !main_up && main_tmr == '0;
	wire main_ok    = main_up || main_start; // Gate, ramp and rails start together
	wire early_uv   = arm1 && (seq == SQ_WAIT || seq == SQ_RAMP2) && |s.uv[1:0];
	wire wait_done  = seq == SQ_WAIT && tmr == '0;

	// Start-up phases; shutdown wins unless already latched off
	always_comb begin
		next_seq = seq;
		unique case (seq)
			SQ_OFF:   if (s.por_ok && !shut) next_seq = SQ_RAMP1;
			SQ_RAMP1: if (s.ramp1) next_seq = SQ_WAIT;
			SQ_WAIT:  if (tmr == '0) next_seq = SQ_RAMP2;
			SQ_RAMP2: if (s.ramp2) next_seq = SQ_RUN;
			SQ_RUN:   next_seq = SQ_RUN;
			SQ_LATCH: next_seq = SQ_LATCH;
		endcase
		if (early_uv)
			next_seq = SQ_LATCH;
		if (!s.por_ok)
			next_seq = SQ_OFF;
		else if (shut && seq != SQ_LATCH)
			next_seq = SQ_OFF;
	end

	// Power state; illegal combinations rely on the system side
	always_comb begin
		next_pw = pw;
		if (!running) begin
			next_pw = wake_req ? PW_ACTIVE : (!filt[1] ? PW_S5 : PW_S3);
		end else begin
			unique case (pw)
				PW_ACTIVE: if (atx_lost) next_pw = PW_S5;
					else if (s3_expired) next_pw = filt[1] ? PW_S3 : PW_S5;
				PW_S3:     if (wake_req) next_pw = PW_ACTIVE;
				PW_S5:     if (wake_req && (!forced || atx_ok)) next_pw = PW_ACTIVE;
			endcase
		end
	end

	// Sequencer and timers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seq      <= SQ_OFF;
			pw       <= PW_ACTIVE;
			tmr      <= '0;
			s3_tmr   <= '0;
			main_tmr <= '0;
			main_up  <= 1'b0;
			forced   <= 1'b0;
		end else begin
			seq      <= next_seq;
			pw       <= next_pw;
			tmr      <= (seq == SQ_RAMP1) ? STARTUP : (tmr != '0 ? tmr - 1'b1 : tmr);
			s3_tmr   <= (pw != PW_ACTIVE || filt[0]) ? S3_DELAY : (s3_tmr != '0 ? s3_tmr - 1'b1 : s3_tmr);
			main_tmr <= !main_cond ? MAIN_WAIT : (main_tmr != '0 ? main_tmr - 1'b1 : main_tmr);
			main_up  <= main_cond && (main_up || main_tmr == '0);
			forced   <= running && (atx_lost || (forced && !atx_ok));
		end
	end

	// Configuration latches; keep-enable frozen while asleep
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			keep_lat              <= 1'b0;
			memory_voltage_select <= 1'b0;
		end else begin
			if (!running || pw == PW_ACTIVE)
				keep_lat <= s.keep;
			if (wait_done)
				memory_voltage_select <= s.memsel;
		end
	end

	// Rail enables; phase-two rails wait for the main timeout when active
	wire base  = (seq == SQ_RAMP1 || seq == SQ_WAIT || seq == SQ_RAMP2 || running) && !ot_off;
	wire up2   = base && (seq == SQ_RAMP2 || running);
	wire act_g = up2 && pw == PW_ACTIVE && main_ok;
	wire [4:0] next_en = {
		up2 && (pw == PW_ACTIVE ? main_ok : keep_lat),
		act_g && !lat_off[3],
		up2 && !lat_off[2] && (pw != PW_ACTIVE || main_ok),
		base && !lat_off[1],
		base};
	wire [4:0] en_q   = {rails.dual5, clock_chip_supply_out, rails.mem, rails.sb18, rails.dual33};
	wire [4:0] armed  = {arm2, arm2, arm2, arm1, arm1};
	wire [4:0] uv_hit = s.uv & armed & en_q;
	// Memory rail is on-chip pass only in sleep
	wire [4:0] int_mask = RAIL_INT | (pw != PW_ACTIVE ? RAIL_MEM : 5'h00);

	// Monitor arming, latch-offs and thermal hysteresis
	always_ff @(posedge aclk) begin
		if (!aresetn || seq == SQ_OFF) begin
			arm1    <= 1'b0;
			arm2    <= 1'b0;
			lat_off <= '0;
		end else begin
			arm1    <= arm1 | (seq == SQ_RAMP1 && s.ramp1);
			arm2    <= arm2 | (seq == SQ_RAMP2 && s.ramp2);
			lat_off <= lat_off | (uv_hit & int_mask);
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ot_off <= 1'b0;
		else
			ot_off <= s.hot155 | (ot_off & s.hot140);
	end

	// Pin outputs, all registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rails                 <= '0;
			clock_chip_supply_out <= 1'b0;
			active_gate_drive     <= 1'b0;
			ss_ramp1              <= 1'b0;
			ss_ramp2              <= 1'b0;
			fault_memsel_pin      <= 1'b0;
			power_state           <= PW_ACTIVE;
		end else begin
			rails                 <= {next_en[4], next_en[2], next_en[1], next_en[0]};
			clock_chip_supply_out <= next_en[3];
			active_gate_drive     <= act_g;
			ss_ramp1              <= seq == SQ_RAMP1;
			ss_ramp2              <= seq == SQ_RAMP2 || main_start;
			fault_memsel_pin      <= seq == SQ_LATCH ||
				(seq != SQ_OFF && (|uv_hit || s.hot140 || forced));
			power_state           <= pw;
		end
	end

	// AXI4-Lite write: address and data taken in any order
	wire aw_take  = awvalid && awready;
	wire w_take   = wvalid && wready;
	wire aw_have  = aw_got || aw_take;
	wire w_have   = w_got || w_take;
	wire do_write = aw_got && w_got && !bvalid;
	wire [1:0] wsel = reg_sel(awaddr_q);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got   <= 1'b0;
			w_got    <= 1'b0;
			awready  <= 1'b0;
			wready   <= 1'b0;
			bvalid   <= 1'b0;
			bresp    <= RESP_OKAY;
			awaddr_q <= '0;
			wdata_q  <= '0;
			wstrb0_q <= 1'b0;
			sw_shut  <= CTRL_RESET;
		end else begin
			aw_got  <= aw_have && !do_write;
			w_got   <= w_have && !do_write;
			awready <= do_write || !aw_have;
			wready  <= do_write || !w_have;
			if (aw_take)
				awaddr_q <= awaddr;
			if (w_take) begin
				wdata_q  <= wdata;
				wstrb0_q <= wstrb[0];
			end
			if (do_write) begin
				bvalid <= 1'b1;
				bresp  <= (wsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
				if (wsel == SEL_CTRL && wstrb0_q)
					sw_shut <= wdata_q[CTRL_SHUT];
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Read mux; status shows sequencer state and latches
	wire [1:0]  rsel   = reg_sel(araddr);
	wire [31:0] status = {16'h0000, lat_off, seq, pw, forced, main_up, ot_off, keep_lat,
		memory_voltage_select, fault_memsel_pin};
	wire [31:0] rword  = (rsel == SEL_CTRL) ? {31'h00000000, sw_shut} :
		(rsel == SEL_STATUS) ? status : (rsel == SEL_SENSE) ? {14'h0000, s} : 32'h00000000;
	wire ar_take = arvalid && arready;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= RESP_OKAY;
		end else begin
			arready <= !ar_take && !(rvalid && !rready);
			if (ar_take) begin
				rvalid <= 1'b1;
				rdata  <= rword;
				rresp  <= (rsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// Checks on the sequencer
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	filter_hold_a:
	assert property ($changed(filt[0]) |-> $past(flt_cnt[0]) == FILT_LAST)
		else $error("sleep request passed filter early");
	s3_delay_a:
	assert property (pw == PW_ACTIVE ##1 pw == PW_S3 |-> $past(s3_tmr) == '0 && $past(running))
		else $error("S3 entered before delay expired");
	gate_mem_a:
	assert property ($rose(active_gate_drive) |-> rails.mem || lat_off[2])
		else $error("gate drive without memory ramp");
	clk_sleep_a:
	assert property (pw != PW_ACTIVE |-> ##1 !clock_chip_supply_out)
		else $error("clock supply on in sleep");
	shut_off_a:
	assert property (shut && seq != SQ_LATCH && !early_uv |-> ##2 (!fault_memsel_pin && rails == '0))
		else $error("shutdown left outputs or fault on");
	latch_hold_a:
	assert property (seq == SQ_LATCH && s.por_ok |=> seq == SQ_LATCH && fault_memsel_pin)
		else $error("latch-off released without POR");
	no_direct_a:
	assert property (running && pw != PW_ACTIVE |=> pw == PW_ACTIVE || $stable(pw))
		else $error("direct sleep to sleep transition");
	forced_s5_a:
	assert property (atx_lost |=> pw == PW_S5 && forced ##1 fault_memsel_pin)
		else $error("mains loss did not force S4/S5");
	keep_sleep_a:
	assert property (running && pw != PW_ACTIVE |=> $stable(keep_lat))
		else $error("keep enable changed in sleep");
	memsel_lat_a:
	assert property (wait_done |=> memory_voltage_select == $past(s.memsel))
		else $error("memory select not latched");

	active_wake_c: cover property ($rose(active_gate_drive));
	s3_entry_c:    cover property (pw == PW_ACTIVE ##1 pw == PW_S3);
	latch_off_c:   cover property ($rose(seq == SQ_LATCH));
	forced_c:      cover property ($rose(forced));
endmodule

// >>> rail_partner.sv
// Purpose: Far-side model: chipset sleep request lines and soft-start cap
// Assumes: Bench changes commands just after a rising edge
// Notes:   Ramp levels report done ramp_dly cycles into each ramp phase
module rail_partner import acpi_rail_pkg::*; (
	input  wire logic       aclk,
	input  wire logic [1:0] req,
	input  wire logic       glitch,
	input  wire logic [4:0] ramp_dly,
	input  wire logic       ss_ramp1,
	input  wire logic       ss_ramp2,
	output logic            suspend_ram_request_n,
	output logic            soft_off_request_n,
	output logic            ramp1_done,
	output logic            ramp2_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] cnt1;
	logic [4:0] cnt2;

	// Request code 0 active, 1 S3, 2 S4/S5; glitch is a commanded noise pulse
	assign suspend_ram_request_n = (req == 2'h0) && !glitch;
	assign soft_off_request_n    = (req != 2'h2);

	// Cap charge time; done drops with the phase, like a discharged cap
	always_ff @(posedge aclk) begin
		cnt1 <= !ss_ramp1 ? 5'h00 : (cnt1 == ramp_dly) ? cnt1 : cnt1 + 5'h01;
		cnt2 <= !ss_ramp2 ? 5'h00 : (cnt2 == ramp_dly) ? cnt2 : cnt2 + 5'h01;
	end
	assign ramp1_done = ss_ramp1 && (cnt1 == ramp_dly);
	assign ramp2_done = ss_ramp2 && (cnt2 == ramp_dly);
endmodule

// >>> tb.sv
// Purpose: Self-checking bench for the ACPI rail sequencer
// Assumes: Short counts: S3 delay 20, startup 30, main wait 40 cycles
// Notes:   Waits carry margins over sync and 400-cycle filter latency
module tb import acpi_rail_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, por = 1'b0, keep = 1'b1, shut = 1'b0;
	logic        memsel_in = 1'b0, t140 = 1'b0, t155 = 1'b0, glitch = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic [1:0]  req = 2'h2, bresp, rresp, rr;
	logic [2:0]  atx = 3'h0;
	logic [4:0]  uv = 5'h00, dly = 5'h03;
	logic        awready, wready, bvalid, arready, rvalid, s3n, s5n, r1d, r2d;
	logic        clk_out, gate, ssr1, ssr2, fault, memsel_out;
	rails_s      rails;
	pwr_e        ps;
	int          err_total = 0, compares = 0, cycles = 0, exp_ps, m, g;

	// 200 MHz clock
	always #2.5 aclk = ~aclk;

	acpi_rail_sequencer #(.S3_DELAY(tmr_t'(20)), .STARTUP(tmr_t'(30)), .MAIN_WAIT(tmr_t'(40)))
	acpi_rail_sequencer_i (
		.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .standby_por_ok(por),
		.suspend_ram_request_n(s3n), .soft_off_request_n(s5n), .sleep_keep_dual5_enable(keep),
		.shutdown_pin(shut), .memsel_compare(memsel_in), .ramp1_done(r1d), .ramp2_done(r2d),
		.temp_140(t140), .temp_155(t155), .atx_good(atx), .rail_uv(uv), .rails(rails),
		.clock_chip_supply_out(clk_out), .active_gate_drive(gate), .ss_ramp1(ssr1),
		.ss_ramp2(ssr2), .fault_memsel_pin(fault), .memory_voltage_select(memsel_out),
		.power_state(ps)
	);

	rail_partner rail_partner_i (
		.aclk(aclk), .req(req), .glitch(glitch), .ramp_dly(dly), .ss_ramp1(ssr1),
		.ss_ramp2(ssr2), .suspend_ram_request_n(s3n), .soft_off_request_n(s5n),
		.ramp1_done(r1d), .ramp2_done(r2d)
	);

	// Hang guard, well above the few thousand cycles the run needs
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// AXI write: hold each channel until its own ready, bready until bvalid
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		awaddr <= a;
		wdata <= d;
		do begin
			@(posedge aclk);
			n++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 50);
		bready <= 1'b0;
		rr = bresp;
		chk(32'(n < 50), 32'h1, "bvalid wait");
	endtask

	// AXI read: data and response taken at the rvalid edge
	task automatic axr(input logic [7:0] a);
		int n;
		n = 0;
		arvalid <= 1'b1;
		rready <= 1'b1;
		araddr <= a;
		do begin
			@(posedge aclk);
			n++;
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 50);
		rready <= 1'b0;
		rd = rdata;
		rr = rresp;
		chk(32'(n < 50), 32'h1, "rvalid wait");
	endtask

	// Model state compared whenever the design settles
	task automatic wait_ps(input int p);
		int n;
		n = 0;
		while (32'(ps) !== p && n < 1500) begin
			@(posedge aclk);
			n++;
		end
		chk(32'(ps), p, "power state");
	endtask

	initial begin
		void'($urandom(65406));
		m = $urandom % 2;
		g = 1 + $urandom % 190;
		cyc(3);
		aresetn <= 1'b1;
		cyc(2);
		// Reset values and decode
		chk(32'(rails), 32'h0, "rails reset");
		chk(32'(ps), 32'(PW_ACTIVE), "state reset");
		axr(8'h0c);
		chk(32'(rr), 32'(RESP_DECERR), "rresp unmapped");
		chk(rd, 32'h0, "rdata unmapped");
		axw(8'h0c, 32'h1);
		chk(32'(rr), 32'(RESP_DECERR), "bresp unmapped");
		axr(REG_CTRL);
		chk(rd, 32'(CTRL_RESET), "ctrl reset");
		// Power-up with S4/S5 requested; requests pass the filter before bias comes up
		memsel_in <= m[0];
		cyc(420);
		por <= 1'b1;
		cyc(6);
		chk(32'(ssr1), 32'h1, "ramp1");
		chk(32'(rails), 32'h3, "phase one rails");
		cyc(60);
		chk(32'(memsel_out), 32'(m), "memsel latch");
		chk(32'(ssr2 | rails.mem), 32'h1, "second ramp");
		exp_ps = 2;
		wait_ps(exp_ps);
		chk(32'(clk_out), 32'h0, "clock in sleep");
		chk(32'(rails), 32'hf, "sleep rails");
		keep <= 1'b0;
		cyc(10);
		chk(32'(rails.dual5), 32'h1, "keep ignored");
		keep <= 1'b1;
		// Wake; outputs wait for mains timeout
		req <= 2'h0;
		atx <= 3'h7;
		exp_ps = 0;
		wait_ps(exp_ps);
		cyc(30);
		chk(32'(gate), 32'h0, "gate early");
		cyc(20);
		chk(32'(gate), 32'h1, "gate on");
		chk(32'(clk_out), 32'h1, "clock active");
		// External-pass undervoltage flags only
		uv <= 5'h04;
		cyc(6);
		chk(32'(fault), 32'h1, "uv flag");
		chk(32'(rails.mem), 32'h1, "uv no latch");
		uv <= 5'h00;
		cyc(6);
		chk(32'(fault), 32'h0, "uv clear");
		// Internal-pass undervoltage latches only that regulator
		uv <= 5'h02;
		cyc(6);
		chk(32'(rails.sb18), 32'h0, "int uv off");
		chk(32'(rails.dual33), 32'h1, "int uv other on");
		uv <= 5'h00;
		cyc(6);
		chk(32'(rails.sb18), 32'h0, "int uv latched");
		// Overtemperature flag, cut-out, resume
		t140 <= 1'b1;
		cyc(6);
		chk(32'(fault), 32'h1, "hot flag");
		chk(32'(gate), 32'h1, "hot running");
		t155 <= 1'b1;
		cyc(6);
		chk(32'(rails), 32'h0, "hot off");
		t155 <= 1'b0;
		t140 <= 1'b0;
		cyc(300);
		chk(32'(gate), 32'h1, "hot resume");
		// Mains loss forces S4/S5 until recovery
		atx <= 3'h6;
		cyc(6);
		chk(32'(ps), 32'(PW_S5), "forced sleep");
		chk(32'(fault), 32'h1, "mains flag");
		atx <= 3'h7;
		wait_ps(exp_ps);
		// Short pulse filtered, then S3 and blocked S3 to S4/S5
		glitch <= 1'b1;
		cyc(g);
		glitch <= 1'b0;
		cyc(450);
		chk(32'(ps), 32'(PW_ACTIVE), "glitch");
		req <= 2'h1;
		exp_ps = 1;
		wait_ps(exp_ps);
		chk(32'(clk_out), 32'h0, "clock in s3");
		chk(32'(rails.dual5), 32'h1, "dual5 in s3");
		req <= 2'h2;
		cyc(450);
		chk(32'(ps), 32'(PW_S3), "s3 to s5 blocked");
		req <= 2'h0;
		exp_ps = 0;
		wait_ps(exp_ps);
		// Shutdown pin with slow ramps
		dly <= 5'h0a;
		uv <= 5'h04;
		shut <= 1'b1;
		cyc(6);
		chk(32'(rails), 32'h0, "shut off");
		chk(32'(fault), 32'h0, "shut flag low");
		uv <= 5'h00;
		shut <= 1'b0;
		cyc(6);
		chk(32'(ssr1), 32'h1, "fresh start");
		chk(32'(rails.sb18), 32'h1, "latch cleared");
		// Software shutdown through the control register
		axw(REG_CTRL, 32'h1);
		cyc(6);
		chk(32'(rails), 32'h0, "sw shut");
		axr(REG_CTRL);
		chk(rd, 32'h1, "ctrl readback");
		axw(REG_CTRL, 32'h0);
		// Phase-one undervoltage latches off until POR
		cyc(22);
		uv <= 5'h01;
		cyc(6);
		chk(32'(fault), 32'h1, "early uv");
		chk(32'(rails), 32'h0, "latched off");
		uv <= 5'h00;
		shut <= 1'b1;
		cyc(6);
		chk(32'(fault), 32'h1, "latch holds");
		shut <= 1'b0;
		por <= 1'b0;
		cyc(6);
		por <= 1'b1;
		cyc(6);
		chk(32'(ssr1), 32'h1, "por clears");
		axr(REG_STATUS);
		chk(32'(rd[10:8]), 32'h1, "seq ramp1");
		cyc(1);
		axr(REG_SENSE);
		chk(32'(rd[17]), 32'h1, "sense por");
		complete_run();
	end
endmodule
